// ===== inc/prs_pkg.sv
// constants, chain layout and state type for the switchover block
// Summary of operation
// - active reference stops toggling: selection moves automatically to the other input if that one is still toggling
// - outputs primary fault, backup fault and which reference is active
// - automatic mode drives the mux select, switching back and forth without limit
// - manual switch request (pin or register) changes the selected reference
// - odd-duty bit balances odd division, e.g. three cycles as 1.5 high, 1.5 low
// - serial reconfiguration chain is exactly 144 bits long
// - seven dividers take 16 count plus 2 control bits; pump and filter 9 each
// - low-count lsb of output divider four is shifted first
// - loop-filter msb is shifted last
// - divider control bits are a bypass bit and an odd-duty select bit
package prs_pkg;

   //////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [5:0] ADDR_CTRL = 6'h00;
   localparam logic [5:0] ADDR_STATUS = 6'h04;
   localparam logic [5:0] ADDR_SCAN_CTRL = 6'h08;
   localparam logic [5:0] ADDR_SCAN_DATA0 = 6'h10;
   localparam int SCAN_WORDS = 5;

   // control and status bit positions, reset values
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_MANUAL_BIT = 1;
   localparam logic CTRL_AUTO_RESET = 1'b1;
   localparam int SCAN_START_BIT = 0;
   localparam int LAST_WORD_BITS = 16;

   //////////////////////////////////////////////////////////////////////////////
   // chain layout
   localparam int CHAIN_BITS = 144;
   localparam int SEG_BITS = 18;
   localparam int CNT_HALF_BITS = 8;
   localparam int SEG_LOW_POS = 0;
   localparam int SEG_HIGH_POS = 8;
   localparam int SEG_BYPASS_POS = 16;
   localparam int SEG_ODD_POS = 17;
   localparam int SEG_DIV4 = 0;
   localparam int SEG_DIV0 = 4;
   localparam int SEG_FB = 5;
   localparam int SEG_PRE = 6;
   localparam int CP_POS = 126;
   localparam int CP_BITS = 9;
   localparam int LF_POS = 135;
   localparam int LF_BITS = 9;
   localparam logic [143:0] CHAIN_RESET = 144'h0;
   localparam logic [7:0] LAST_BIT_IDX = 8'h8f;

   //////////////////////////////////////////////////////////////////////////////
   // timing: a reference is lost after this long without an edge
   localparam int CLK_MHZ = 200;
   localparam int REF_LOSS_NS = 100;
   localparam int REF_LOSS_CYC_INT = (REF_LOSS_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] REF_LOSS_CYC = 8'(REF_LOSS_CYC_INT);

   // selection state, gray along primary -> backup -> primary
   typedef enum logic [1:0] {
      ST_PRI = 2'b00,
      ST_TO_BKP = 2'b01,
      ST_BKP = 2'b11,
      ST_TO_PRI = 2'b10
   } prs_sel_state_t;

endpackage : prs_pkg

// ===== hw/prs_odd_div.sv
// output divider that counts half periods of the selected reference
`timescale 1ns/1ps
`default_nettype none
module prs_odd_div (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // reference half-period strobe and level
   input wire logic half_tick,
   input wire logic ref_level,
   // divider settings
   input wire logic [7:0] high_count,
   input wire logic [7:0] low_count,
   input wire logic bypass,
   input wire logic odd_sel,
   // divided clock
   output logic div_clk
);

   logic phase_q, phase_d;
   logic [8:0] cnt_q, cnt_d;
   logic out_q, out_d;
   logic [8:0] high_half, low_half, limit;

   // odd select trades one half period from high to low time
   always_comb begin
      high_half = {high_count, 1'b0} - {8'h00, odd_sel};
      low_half = {low_count, 1'b0} + {8'h00, odd_sel};
      if (high_half == 9'h000) high_half = 9'h001;
      if (low_half == 9'h000) low_half = 9'h001;
      limit = phase_q ? high_half : low_half;
   end

   // count half periods, flip phase when the current phase is used up
   always_comb begin
      phase_d = phase_q;
      cnt_d = cnt_q;
      out_d = phase_q;
      if (bypass) begin
         out_d = ref_level; // counter skipped
         cnt_d = 9'h000;
      end else if (half_tick) begin
         if (cnt_q + 9'h001 >= limit) begin
            phase_d = ~phase_q;
            cnt_d = 9'h000;
         end else begin
            cnt_d = cnt_q + 9'h001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         phase_q <= 1'b0;
         cnt_q <= 9'h000;
         out_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign div_clk = out_q;

endmodule : prs_odd_div
`default_nettype wire

// ===== hw/prs_top.sv
// switchover, clock sense and scan chain behind avalon-mm
`timescale 1ns/1ps
`default_nettype none
module prs_top (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // references, synchronous levels
   input wire logic primary_ref_in,
   input wire logic backup_ref_in,
   // user switch request, rising edge acts
   input wire logic manual_switch_req,
   // avalon-mm slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // switchover status
   output logic primary_ref_fault,
   output logic backup_ref_fault,
   output logic active_ref,
   output logic selected_ref,
   // serial chain out
   output logic scan_data,
   output logic scan_valid,
   output logic scan_busy,
   // applied settings
   output logic div_zero_clk,
   output logic [8:0] charge_pump_setting,
   output logic [8:0] loop_filter_setting
);

   //////////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane merge for register writes
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[8*i +: 8] = new_v[8*i +: 8];
      end
      return r;
   endfunction : merge_bytes

   // one divider segment, divider four at the chain head
   function automatic logic [17:0] seg_of(input logic [143:0] chain, input int idx);
      return chain[idx*prs_pkg::SEG_BITS +: prs_pkg::SEG_BITS];
   endfunction : seg_of

   //////////////////////////////////////////////////////////////////////////////
   // clock sense

   logic [1:0] ref_now, ref_last_q, ref_last_d;
   logic [1:0] fault_q, fault_d;
   logic [7:0] idle_q [2];
   logic [7:0] idle_d [2];

   assign ref_now = {backup_ref_in, primary_ref_in};

   // idle for the loss time sets the flag; an edge clears it
   always_comb begin
      ref_last_d = ref_now;
      for (int i = 0; i < 2; i++) begin
         idle_d[i] = idle_q[i];
         fault_d[i] = fault_q[i];
         if (ref_now[i] != ref_last_q[i]) begin
            idle_d[i] = 8'h00;
            fault_d[i] = 1'b0;
         end else if (idle_q[i] >= prs_pkg::REF_LOSS_CYC - 8'h01) begin
            fault_d[i] = 1'b1; // stopped toggling
         end else begin
            idle_d[i] = idle_q[i] + 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ref_last_q <= 2'b00;
         fault_q <= 2'b00;
         idle_q[0] <= 8'h00;
         idle_q[1] <= 8'h00;
      end else begin
         ref_last_q <= ref_last_d;
         fault_q <= fault_d;
         idle_q[0] <= idle_d[0];
         idle_q[1] <= idle_d[1];
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, then the answer

   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic auto_q, auto_d;
   logic sw_switch_q, sw_switch_d;
   logic [31:0] word_q [prs_pkg::SCAN_WORDS];
   logic [31:0] word_d [prs_pkg::SCAN_WORDS];
   logic wr_fire, scan_start;
   logic busy_q, busy_d, active_q, active_d;
   logic [143:0] image;

   assign wr_fire = avs_write && !wait_q;

   // words 0..3 full, last word only its low half
   always_comb begin
      for (int w = 0; w < prs_pkg::SCAN_WORDS - 1; w++) image[w*32 +: 32] = word_q[w];
      image[(prs_pkg::SCAN_WORDS-1)*32 +: prs_pkg::LAST_WORD_BITS] =
         word_q[prs_pkg::SCAN_WORDS-1][prs_pkg::LAST_WORD_BITS-1:0];
   end

   // one wait cycle; read data ready when waitrequest drops
   always_comb begin
      wait_d = 1'b1;
      rdata_d = rdata_q;
      if ((avs_read || avs_write) && wait_q) begin
         wait_d = 1'b0;
         rdata_d = 32'h0000_0000;
         if (avs_read) begin
            if (avs_address == prs_pkg::ADDR_CTRL) begin
               rdata_d[prs_pkg::CTRL_AUTO_BIT] = auto_q;
            end else if (avs_address == prs_pkg::ADDR_STATUS) begin
               rdata_d[3:0] = {busy_q, active_q, fault_q};
            end else if (avs_address == prs_pkg::ADDR_SCAN_CTRL) begin
               rdata_d[prs_pkg::SCAN_START_BIT] = busy_q;
            end else begin
               for (int w = 0; w < prs_pkg::SCAN_WORDS; w++) begin
                  if (avs_address == prs_pkg::ADDR_SCAN_DATA0 + 6'(4*w)) begin
                     rdata_d = (w == prs_pkg::SCAN_WORDS-1) ?
                        {16'h0000, word_q[w][15:0]} : word_q[w];
                  end
               end
            end
         end
      end
   end

   // register writes; manual switch bit is a self-clearing pulse
   always_comb begin
      auto_d = auto_q;
      sw_switch_d = 1'b0;
      scan_start = 1'b0;
      for (int w = 0; w < prs_pkg::SCAN_WORDS; w++) word_d[w] = word_q[w];
      if (wr_fire) begin
         if (avs_address == prs_pkg::ADDR_CTRL) begin
            if (avs_byteenable[0]) begin
               auto_d = avs_writedata[prs_pkg::CTRL_AUTO_BIT];
               sw_switch_d = avs_writedata[prs_pkg::CTRL_MANUAL_BIT];
            end
         end else if (avs_address == prs_pkg::ADDR_SCAN_CTRL) begin
            // a start while shifting is ignored
            scan_start = avs_byteenable[0] && avs_writedata[prs_pkg::SCAN_START_BIT] && !busy_q;
         end else begin
            for (int w = 0; w < prs_pkg::SCAN_WORDS; w++) begin
               if (avs_address == prs_pkg::ADDR_SCAN_DATA0 + 6'(4*w)) begin
                  word_d[w] = merge_bytes(word_q[w], avs_writedata, avs_byteenable);
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         auto_q <= prs_pkg::CTRL_AUTO_RESET;
         sw_switch_q <= 1'b0;
         for (int w = 0; w < prs_pkg::SCAN_WORDS; w++) word_q[w] <= 32'h0000_0000;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         auto_q <= auto_d;
         sw_switch_q <= sw_switch_d;
         for (int w = 0; w < prs_pkg::SCAN_WORDS; w++) word_q[w] <= word_d[w];
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // switchover state machine

   prs_pkg::prs_sel_state_t state_q, state_d;
   logic man_last_q, man_last_d;
   logic switch_req;
   logic sel_out_q, sel_out_d;
   logic sel_last_q, sel_last_d;

   // pin edge or register pulse; usable at any frequency ratio
   assign switch_req = (manual_switch_req && !man_last_q) || sw_switch_q;

   // fail over only to a live input, so it can bounce forever
   always_comb begin
      man_last_d = manual_switch_req;
      state_d = state_q;
      case (state_q)
         prs_pkg::ST_PRI: begin
            if (switch_req || (auto_q && fault_q[0] && !fault_q[1])) state_d = prs_pkg::ST_TO_BKP;
         end
         prs_pkg::ST_TO_BKP: begin
            state_d = prs_pkg::ST_BKP;
         end
         prs_pkg::ST_BKP: begin
            if (switch_req || (auto_q && fault_q[1] && !fault_q[0])) state_d = prs_pkg::ST_TO_PRI;
         end
         default: begin
            state_d = prs_pkg::ST_PRI;
         end
      endcase
   end

   // mux select follows the state; output held low one cycle across a swap
   always_comb begin
      active_d = (state_d == prs_pkg::ST_TO_BKP) || (state_d == prs_pkg::ST_BKP);
      if ((state_d == prs_pkg::ST_TO_BKP) || (state_d == prs_pkg::ST_TO_PRI)) begin
         sel_out_d = 1'b0; // avoids a runt pulse from mixing the two inputs
      end else begin
         sel_out_d = active_d ? backup_ref_in : primary_ref_in;
      end
      sel_last_d = sel_out_q;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= prs_pkg::ST_PRI;
         man_last_q <= 1'b0;
         active_q <= 1'b0;
         sel_out_q <= 1'b0;
         sel_last_q <= 1'b0;
      end else begin
         state_q <= state_d;
         man_last_q <= man_last_d;
         active_q <= active_d;
         sel_out_q <= sel_out_d;
         sel_last_q <= sel_last_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // reconfiguration chain: rotate out 144 bits, then apply

   logic [143:0] shift_q, shift_d;
   logic [143:0] applied_q, applied_d;
   logic [7:0] bit_q, bit_d;
   logic sdata_q, sdata_d;
   logic svalid_q, svalid_d;

   // bit 0 leaves first, bit 143 last
   always_comb begin
      shift_d = shift_q;
      applied_d = applied_q;
      bit_d = bit_q;
      busy_d = busy_q;
      sdata_d = 1'b0;
      svalid_d = 1'b0;
      if (scan_start) begin
         shift_d = image;
         bit_d = 8'h00;
         busy_d = 1'b1;
      end else if (busy_q) begin
         sdata_d = shift_q[0];
         svalid_d = 1'b1;
         shift_d = {shift_q[0], shift_q[143:1]};
         bit_d = bit_q + 8'h01;
         if (bit_q == prs_pkg::LAST_BIT_IDX) begin
            busy_d = 1'b0; // last bit out
            applied_d = shift_d; // rotation restores the full image
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         shift_q <= prs_pkg::CHAIN_RESET;
         applied_q <= prs_pkg::CHAIN_RESET;
         bit_q <= 8'h00;
         busy_q <= 1'b0;
         sdata_q <= 1'b0;
         svalid_q <= 1'b0;
      end else begin
         shift_q <= shift_d;
         applied_q <= applied_d;
         bit_q <= bit_d;
         busy_q <= busy_d;
         sdata_q <= sdata_d;
         svalid_q <= svalid_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // divider zero from its applied segment

   logic [17:0] div0_seg;
   logic half_tick;

   assign div0_seg = seg_of(applied_q, prs_pkg::SEG_DIV0);
   assign half_tick = sel_out_q ^ sel_last_q;

   prs_odd_div u_div_zero (
      .clk(clk),
      .reset(reset),
      .half_tick(half_tick),
      .ref_level(sel_out_q),
      .high_count(div0_seg[prs_pkg::SEG_HIGH_POS +: prs_pkg::CNT_HALF_BITS]),
      .low_count(div0_seg[prs_pkg::SEG_LOW_POS +: prs_pkg::CNT_HALF_BITS]),
      .bypass(div0_seg[prs_pkg::SEG_BYPASS_POS]),
      .odd_sel(div0_seg[prs_pkg::SEG_ODD_POS]),
      .div_clk(div_zero_clk)
   );

   //////////////////////////////////////////////////////////////////////////////
   // port drives, all from flip-flops

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign primary_ref_fault = fault_q[0];
   assign backup_ref_fault = fault_q[1];
   assign active_ref = active_q;
   assign selected_ref = sel_out_q;
   assign scan_data = sdata_q;
   assign scan_valid = svalid_q;
   assign scan_busy = busy_q;
   assign charge_pump_setting = applied_q[prs_pkg::CP_POS +: prs_pkg::CP_BITS];
   assign loop_filter_setting = applied_q[prs_pkg::LF_POS +: prs_pkg::LF_BITS];

endmodule : prs_top
`default_nettype wire

// ===== test/prs_top_sva.sv
// checks on switchover, bus handshake and scan chain ports
`timescale 1ns/1ps
`default_nettype none
module prs_top_sva (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // references and request
   input wire logic primary_ref_in,
   input wire logic backup_ref_in,
   input wire logic manual_switch_req,
   // bus
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   // status and chain
   input wire logic primary_ref_fault,
   input wire logic backup_ref_fault,
   input wire logic active_ref,
   input wire logic selected_ref,
   input wire logic scan_data,
   input wire logic scan_valid,
   input wire logic scan_busy,
   input wire logic [8:0] charge_pump_setting,
   input wire logic [8:0] loop_filter_setting
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic auto_q, auto_d, pp_q, bp_q;
   logic [7:0] pc_q, pc_d, bc_q, bc_d, vc_q, vc_d;
   logic [17:0] sh_q, sh_d;
   ////////////////////////////////////////////////////////////////
   // shadow of auto enable, idle counters, chain tail; idle counters saturate
   always_comb begin
      auto_d = auto_q;
      if (avs_write && !avs_waitrequest && avs_address == prs_pkg::ADDR_CTRL) begin
         auto_d = avs_byteenable[0] ? avs_writedata[prs_pkg::CTRL_AUTO_BIT] : auto_q;
      end
      pc_d = (primary_ref_in != pp_q) ? 8'h00 : pc_q + {7'h00, pc_q != 8'hff};
      bc_d = (backup_ref_in != bp_q) ? 8'h00 : bc_q + {7'h00, bc_q != 8'hff};
      vc_d = scan_valid ? vc_q + 8'h01 : 8'h00;
      sh_d = scan_valid ? {scan_data, sh_q[17:1]} : sh_q;
   end
   always_ff @(posedge clk) begin
      pp_q <= primary_ref_in;
      bp_q <= backup_ref_in;
      sh_q <= sh_d;
      auto_q <= reset ? prs_pkg::CTRL_AUTO_RESET : auto_d;
      pc_q <= reset ? 8'h00 : pc_d;
      bc_q <= reset ? 8'h00 : bc_d;
      vc_q <= reset ? 8'h00 : vc_d;
   end
   ////////////////////////////////////////////////////////////////
   // margins around the 20-cycle loss time absorb sampling latency
   AST_BUS_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus wait not one cycle");
   AST_PRI_FAULT: assert property (
      (pc_q >= 8'h02 && pc_q <= 8'h10 |-> !primary_ref_fault) and
      (pc_q >= 8'h18 |-> primary_ref_fault)) else $error("primary fault wrong");
   AST_BKP_FAULT: assert property (
      (bc_q >= 8'h02 && bc_q <= 8'h10 |-> !backup_ref_fault) and
      (bc_q >= 8'h18 |-> backup_ref_fault)) else $error("backup fault wrong");
   AST_AUTO_TO_BKP: assert property (
      $rose(primary_ref_fault) && !backup_ref_fault && !active_ref && auto_q
      |=> active_ref) else $error("no automatic move to backup");
   AST_AUTO_TO_PRI: assert property (
      $rose(backup_ref_fault) && !primary_ref_fault && active_ref && auto_q
      |=> !active_ref) else $error("no automatic move to primary");
   AST_MANUAL: assert property (
      $rose(manual_switch_req) && $stable(active_ref)
      |-> ##[1:2] $changed(active_ref)) else $error("manual request ignored");
   AST_SEL_FORCE: assert property ($changed(active_ref) |-> !selected_ref)
      else $error("selected not low in swap");
   AST_SCAN_START: assert property ($rose(scan_busy) |=> scan_valid && scan_busy)
      else $error("scan did not start");
   AST_SCAN_END: assert property (scan_valid && !scan_busy |=> !scan_valid)
      else $error("scan ran past busy");
   AST_SCAN_LEN: assert property ($fell(scan_valid) |-> vc_q == 8'h90)
      else $error("scan length not 144");
   AST_SCAN_SET: assert property ($fell(scan_valid) |->
      charge_pump_setting == sh_q[8:0] && loop_filter_setting == sh_q[17:9])
      else $error("applied pump or filter wrong");
endmodule : prs_top_sva
bind prs_top prs_top_sva i_prs_top_sva (.*);
`default_nettype wire

// ===== test/prs_ref_model.sv
// reference sources and user switch logic
`timescale 1ns/1ps
`default_nettype none
module prs_ref_model #(
   parameter int PRI_HALF = 2,
   parameter int BKP_HALF = 3
) (
   // clock
   input wire logic clk,
   // bench control
   input wire logic pri_run,
   input wire logic bkp_run,
   input wire logic swap_go,
   // toward the block
   output var logic primary_ref_in,
   output var logic backup_ref_in,
   output var logic manual_switch_req
);
   int pc = 0;
   int bc = 0;
   initial begin
      primary_ref_in = 1'b0;
      backup_ref_in = 1'b0;
      manual_switch_req = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // a stopped source freezes at its level, like a dead oscillator
   always @(posedge clk) begin
      pc <= (pri_run && pc < PRI_HALF - 1) ? pc + 1 : 0;
      bc <= (bkp_run && bc < BKP_HALF - 1) ? bc + 1 : 0;
      if (pri_run && pc == PRI_HALF - 1) begin
         primary_ref_in <= !primary_ref_in;
      end
      if (bkp_run && bc == BKP_HALF - 1) begin
         backup_ref_in <= !backup_ref_in;
      end
      // unequal rates, so the user side swaps by request
      manual_switch_req <= swap_go;
   end
endmodule : prs_ref_model
`default_nettype wire

// ===== test/prs_top_bench.sv
// bench for the switchover and scan chain block
`timescale 1ns/1ps
`default_nettype none
module prs_top_bench;
   localparam int PH = 2;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic pri_run = 1'b1;
   logic bkp_run = 1'b1;
   logic swap_go = 1'b0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, primary_ref_fault, backup_ref_fault, active_ref, selected_ref;
   logic scan_data, scan_valid, scan_busy, div_zero_clk;
   logic primary_ref_in, backup_ref_in, manual_switch_req;
   logic [8:0] charge_pump_setting, loop_filter_setting;
   int err_count = 0;
   int samples_checked = 0;
   ////////////////////////////////////////////////////////////////
   // clock, block and sources
   initial forever #2.5 clk = ~clk;
   prs_top i_prs_top (.*);
   prs_ref_model #(.PRI_HALF(PH), .BKP_HALF(3)) i_prs_ref_model (.*);
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
   endtask : bus
   task automatic rdc(input logic [5:0] a, input string what, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(what, exp, rd);
   endtask : rdc
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rdc(prs_pkg::ADDR_CTRL, "ctrl reset", 32'h1);
      rdc(prs_pkg::ADDR_STATUS, "status reset", 32'h0);
      bus(1'b1, 6'h0c, 32'hffff_ffff, 4'hf);
      rdc(6'h0c, "unmapped", 32'h0);
      $display("test regs done");
   endtask : t_regs
   // load, start, restart while busy, collect every bit
   task automatic t_scan;
      logic [31:0] w [5] = '{32'ha5c3_0f01, 32'h8421_7e3c, 32'h0ff0_5aa5, 32'hc001_d00d,
                             32'hffff_b3e9};
      logic [143:0] ev, gv;
      int i, n;
      for (i = 0; i < 5; i++) begin
         bus(1'b1, prs_pkg::ADDR_SCAN_DATA0 + 6'(4 * i), w[i], 4'hf);
      end
      bus(1'b1, prs_pkg::ADDR_SCAN_DATA0, 32'hffff_ffff, 4'hc);
      ev = {w[4][15:0], w[3], w[2], w[1], 16'hffff, w[0][15:0]};
      rdc(prs_pkg::ADDR_SCAN_DATA0, "scan word0", ev[31:0]);
      rdc(prs_pkg::ADDR_SCAN_DATA0 + 6'h10, "scan word4", 32'(ev[143:128]));
      n = 0;
      fork
         begin
            bus(1'b1, prs_pkg::ADDR_SCAN_CTRL, 32'h1, 4'hf);
            repeat (20) @(posedge clk);
            bus(1'b1, prs_pkg::ADDR_SCAN_CTRL, 32'h1, 4'hf);
         end
         for (i = 0; i < 400 && n < 144; i++) begin
            @(posedge clk);
            if (scan_valid === 1'b1) begin
               gv[n] = scan_data;
               n++;
            end
         end
      join
      chk("scan bit count", 32'd144, 32'(n));
      for (i = 0; i < 144; i++) begin
         chk("scan bit", 32'(ev[i]), 32'(gv[i]));
      end
      chk("charge pump", 32'(ev[134:126]), 32'(charge_pump_setting));
      chk("loop filter", 32'(ev[143:135]), 32'(loop_filter_setting));
      repeat (4) @(posedge clk);
      chk("no second scan", 32'h0, {30'h0, scan_valid, scan_busy});
      rdc(prs_pkg::ADDR_SCAN_CTRL, "scan idle", 32'h0);
      $display("test scan done");
   endtask : t_scan
   // divider zero: high 2, low 1 with odd, plain and bypassed
   task automatic t_div;
      logic [1:0] cf [3] = '{2'b10, 2'b00, 2'b01};
      int k, n, hi, lo;
      for (k = 0; k < 3; k++) begin
         bus(1'b1, prs_pkg::ADDR_SCAN_DATA0 + 6'h08, {6'h0, cf[k], 24'h02_0100}, 4'hf);
         bus(1'b1, prs_pkg::ADDR_SCAN_CTRL, 32'h1, 4'hf);
         for (n = 0; n < 20 && scan_busy !== 1'b1; n++) @(posedge clk);
         for (n = 0; n < 300 && scan_busy !== 1'b0; n++) @(posedge clk);
         for (n = 0; n < 60 && div_zero_clk !== 1'b0; n++) @(posedge clk);
         for (n = 0; n < 60 && div_zero_clk !== 1'b1; n++) @(posedge clk);
         hi = 0;
         lo = 0;
         for (n = 0; n < 60 && div_zero_clk === 1'b1; n++) begin
            @(posedge clk);
            hi++;
         end
         for (n = 0; n < 60 && div_zero_clk === 1'b0; n++) begin
            @(posedge clk);
            lo++;
         end
         chk("div high", 32'(cf[k][0] ? PH : PH * (4 - cf[k][1])), 32'(hi));
         chk("div low", 32'(cf[k][0] ? PH : PH * (2 + cf[k][1])), 32'(lo));
      end
      $display("test divider done");
   endtask : t_div
   // lose primary, then backup: selection moves over and back
   task automatic t_auto;
      int n;
      pri_run <= 1'b0;
      for (n = 0; n < 80 && active_ref !== 1'b1; n++) @(posedge clk);
      rdc(prs_pkg::ADDR_STATUS, "status primary lost", 32'h5);
      pri_run <= 1'b1;
      for (n = 0; n < 80 && primary_ref_fault !== 1'b0; n++) @(posedge clk);
      bkp_run <= 1'b0;
      for (n = 0; n < 80 && active_ref !== 1'b0; n++) @(posedge clk);
      rdc(prs_pkg::ADDR_STATUS, "status backup lost", 32'h2);
      bkp_run <= 1'b1;
      for (n = 0; n < 80 && backup_ref_fault !== 1'b0; n++) @(posedge clk);
      $display("test auto done");
   endtask : t_auto
   // auto off: pin and register swaps only, a lost input stays selected
   task automatic t_manual;
      int n;
      bus(1'b1, prs_pkg::ADDR_CTRL, 32'h0, 4'hf);
      swap_go <= 1'b1;
      @(posedge clk);
      swap_go <= 1'b0;
      for (n = 0; n < 10 && active_ref !== 1'b1; n++) @(posedge clk);
      chk("pin swap", 32'h1, {31'h0, active_ref});
      bus(1'b1, prs_pkg::ADDR_CTRL, 32'h2, 4'hf);
      for (n = 0; n < 10 && active_ref !== 1'b0; n++) @(posedge clk);
      chk("register swap", 32'h0, {31'h0, active_ref});
      rdc(prs_pkg::ADDR_CTRL, "ctrl manual", 32'h0);
      pri_run <= 1'b0;
      repeat (40) @(posedge clk);
      rdc(prs_pkg::ADDR_STATUS, "no auto swap", 32'h1);
      pri_run <= 1'b1;
      $display("test manual done");
   endtask : t_manual
   ////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_scan();
      t_div();
      t_auto();
      t_manual();
      final_report();
   end
   // a hang counts as a mismatch; the tests need roughly a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("[ERR] watchdog expected done seen hang");
      final_report();
   end
endmodule : prs_top_bench
`default_nettype wire
